// file: hw/crr_pkg.sv
// Package for the conversion result register bank.
// Assumes a 32-bit AXI4-Lite register bus and 10-bit conversion results.
package crr_pkg;

  // Result and register widths
  localparam int RES_W = 10;
  localparam int REG_W = 8;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_TEMP_SUPPLY_LOW  = 8'h03;
  localparam logic [7:0] IDX_REMOTE_LOW       = 8'h04;
  localparam logic [7:0] IDX_SUPPLY_HIGH      = 8'h06;
  localparam logic [7:0] IDX_INT_TEMP_HIGH    = 8'h07;
  localparam logic [7:0] IDX_REMOTE_ONE_HIGH  = 8'h08;
  localparam logic [7:0] IDX_INPUT_TWO_HIGH   = 8'h09;
  localparam logic [7:0] IDX_INPUT_SELECT     = 8'h20;

  // Input select field positions in the select register
  localparam int SEL_LOW_POS  = 1;
  localparam int SEL_HIGH_POS = 2;

  // Reset values
  localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
  localparam logic [1:0]       SELECT_RST = 2'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : crr_pkg

// file: hw/crr_result_bank.sv
// Conversion result register bank on an AXI4-Lite slave; read-only except the input select register.
// Assumes converter results arrive on core_clk with one-cycle load strobes.
`timescale 1ns/1ns

// Contract
// - Reg 0x03: temp low bits 1:0, supply 3:2
// - Reg 0x04: inputs two-four in pairs 3:2,5:4,7:6
// - Reg 0x04 bits 1:0 follow input select
// - Supply high holds bits 9:2, zero after reset
// - Internal temp high holds bits 9:2
// - Remote high holds selected result bits 9:2
// - Input two high holds bits 9:2
// - Other results read zero after reset
module crr_result_bank
  import crr_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // Converter results, one strobe each
  input  wire logic             intTempLoad,
  input  wire logic [RES_W-1:0] intTempVal,
  input  wire logic             supplyLoad,
  input  wire logic [RES_W-1:0] supplyVal,
  input  wire logic             remoteTempLoad,
  input  wire logic [RES_W-1:0] remoteTempVal,
  input  wire logic [3:0]       inputLoad,
  input  wire logic [RES_W-1:0] inputVal [4],
  // AXI4-Lite write address
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [7:0]       s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  // AXI4-Lite write response
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  output logic      [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  input  wire logic [7:0]       s_axi_araddr,
  // AXI4-Lite read data
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic      [31:0]      s_axi_rdata,
  output logic      [1:0]       s_axi_rresp
);

  // Stored results: 0 internal temp, 1 supply, 2 remote temp, 3..6 inputs
  localparam int NSLOT = 7;
  logic             slotLoad [NSLOT];
  logic [RES_W-1:0] slotIn   [NSLOT];
  logic [RES_W-1:0] slotVal  [NSLOT];

  // Input select, written by software
  logic [1:0]       select_q;
  logic             awHeld_q, wHeld_q;
  logic [7:0]       awAddr_q;
  logic [31:0]      wData_q;
  logic [3:0]       wStrb_q;
  logic             bvalid_q, rvalid_q;
  logic [1:0]       bresp_q, rresp_q;
  logic [31:0]      rdata_q;

  // Strobe and data routing to the result slots
  always_comb begin
    slotLoad[0] = intTempLoad;
    slotIn[0]   = intTempVal;
    slotLoad[1] = supplyLoad;
    slotIn[1]   = supplyVal;
    slotLoad[2] = remoteTempLoad;
    slotIn[2]   = remoteTempVal;
    for (int i = 0; i < 4; i++) begin
      slotLoad[3+i] = inputLoad[i];
      slotIn[3+i]   = inputVal[i];
    end
  end

  // Result storage, loaded only by the converter
  for (genvar g = 0; g < NSLOT; g++) begin : gSlot
    crr_result_slot #(
      .RST_VAL (RESULT_RST)
    ) uSlot (
      .core_clk (core_clk),
      .resetn   (resetn),
      .loadEn   (slotLoad[g]),
      .loadVal  (slotIn[g]),
      .value    (slotVal[g])
    );
  end

  // Remote selection: nonzero select picks the remote sensor
  logic             remoteSel;
  logic [RES_W-1:0] remoteRes;
  always_comb begin
    remoteSel = (select_q != SELECT_RST);
    remoteRes = remoteSel ? slotVal[2] : slotVal[3];
  end

  // Register read mux
  logic [7:0] rdByte;
  logic       rdHit;
  always_comb begin
    rdByte = 8'h00;
    rdHit  = 1'b1;
    case (s_axi_araddr[7:2])
      IDX_TEMP_SUPPLY_LOW[5:0]:
        rdByte = {4'h0, slotVal[1][1:0], slotVal[0][1:0]};
      IDX_REMOTE_LOW[5:0]:
        rdByte = {slotVal[6][1:0], slotVal[5][1:0],
                  slotVal[4][1:0], remoteRes[1:0]};
      IDX_SUPPLY_HIGH[5:0]:     rdByte = slotVal[1][9:2];
      IDX_INT_TEMP_HIGH[5:0]:   rdByte = slotVal[0][9:2];
      IDX_REMOTE_ONE_HIGH[5:0]: rdByte = remoteRes[9:2];
      IDX_INPUT_TWO_HIGH[5:0]:  rdByte = slotVal[4][9:2];
      IDX_INPUT_SELECT[5:0]:
        rdByte = {5'h00, select_q, 1'b0};
      default:                  rdHit  = 1'b0;
    endcase
  end

  // Write address and data capture, taken in either order
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_q <= 1'b1;
      awAddr_q <= s_axi_awaddr;
    end else if (awHeld_q && wHeld_q) begin
      awHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wHeld_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_q <= 1'b1;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end else if (awHeld_q && wHeld_q) begin
      wHeld_q <= 1'b0;
    end
  end

  // Next hold and valid state, so the readies can come from flops
  logic awHeld_d, wHeld_d, bvalid_d, rvalid_d;
  logic awready_q, wready_q, arready_q;
  always_comb begin
    awHeld_d = awHeld_q;
    wHeld_d  = wHeld_q;
    bvalid_d = bvalid_q;
    rvalid_d = rvalid_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_d = 1'b1;
    end else if (awHeld_q && wHeld_q) begin
      awHeld_d = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_d = 1'b1;
    end else if (awHeld_q && wHeld_q) begin
      wHeld_d = 1'b0;
    end
    if (awHeld_q && wHeld_q) begin
      bvalid_d = 1'b1;
    end else if (s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
    end else if (s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Registered readies: refuse while a channel is held or answered
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      arready_q <= 1'b1;
    end else begin
      awready_q <= !awHeld_d && !bvalid_d;
      wready_q  <= !wHeld_d && !bvalid_d;
      arready_q <= !rvalid_d;
    end
  end

  // Write commit: only the select register is writable
  logic wrSel;
  assign wrSel = awHeld_q && wHeld_q &&
                 (awAddr_q[7:2] == IDX_INPUT_SELECT[5:0]);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      select_q <= SELECT_RST;
    end else if (wrSel && wStrb_q[0]) begin
      select_q <= wData_q[SEL_HIGH_POS:SEL_LOW_POS];
    end
  end

  // Write response; result offsets answer OKAY but store nothing
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (awHeld_q && wHeld_q) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (awAddr_q[7:2] == IDX_INPUT_SELECT[5:0] ||
                   awAddr_q[7:2] <= IDX_INPUT_TWO_HIGH[5:0]) ?
                  RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h000000, rdByte};
      rresp_q  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_arready = arready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Helper: read of a given offset in flight
  logic rdTake;
  assign rdTake = s_axi_arvalid && s_axi_arready;

  property p_low_pack;
    @(posedge core_clk) disable iff (!resetn)
    rdTake && s_axi_araddr[7:2] == IDX_TEMP_SUPPLY_LOW[5:0] |=>
      rdata_q[7:0] == {4'h0, $past(slotVal[1][1:0]),
                       $past(slotVal[0][1:0])};
  endproperty
  a_low_pack: assert property (p_low_pack)
    else $error("temp and supply low bits misplaced");

  property p_remote_low;
    @(posedge core_clk) disable iff (!resetn)
    rdTake && s_axi_araddr[7:2] == IDX_REMOTE_LOW[5:0] |=>
      rdata_q[7:2] == {$past(slotVal[6][1:0]), $past(slotVal[5][1:0]),
                       $past(slotVal[4][1:0])};
  endproperty
  a_remote_low: assert property (p_remote_low)
    else $error("input low bits misplaced");

  property p_sel_low;
    @(posedge core_clk) disable iff (!resetn)
    rdTake && s_axi_araddr[7:2] == IDX_REMOTE_LOW[5:0] |=>
      rdata_q[1:0] == ($past(select_q) != SELECT_RST ?
        $past(slotVal[2][1:0]) : $past(slotVal[3][1:0]));
  endproperty
  a_sel_low: assert property (p_sel_low)
    else $error("selected low bits wrong");

  property p_supply_high;
    @(posedge core_clk) disable iff (!resetn)
    rdTake && s_axi_araddr[7:2] == IDX_SUPPLY_HIGH[5:0] |=>
      rdata_q == {24'h000000, $past(slotVal[1][9:2])};
  endproperty
  a_supply_high: assert property (p_supply_high)
    else $error("supply high byte wrong");

  property p_temp_high;
    @(posedge core_clk) disable iff (!resetn)
    rdTake && s_axi_araddr[7:2] == IDX_INT_TEMP_HIGH[5:0] |=>
      rdata_q == {24'h000000, $past(slotVal[0][9:2])};
  endproperty
  a_temp_high: assert property (p_temp_high)
    else $error("temperature high byte wrong");

  property p_temp_load;
    @(posedge core_clk) disable iff (!resetn)
    intTempLoad |=> slotVal[0] == $past(intTempVal);
  endproperty
  a_temp_load: assert property (p_temp_load)
    else $error("temperature result not stored");

  property p_remote_high;
    @(posedge core_clk) disable iff (!resetn)
    rdTake && s_axi_araddr[7:2] == IDX_REMOTE_ONE_HIGH[5:0] |=>
      rdata_q[7:0] == ($past(remoteSel) ? $past(slotVal[2][9:2])
                                        : $past(slotVal[3][9:2]));
  endproperty
  a_remote_high: assert property (p_remote_high)
    else $error("remote high byte wrong");

  property p_in2_high;
    @(posedge core_clk) disable iff (!resetn)
    rdTake && s_axi_araddr[7:2] == IDX_INPUT_TWO_HIGH[5:0] |=>
      rdata_q[7:0] == $past(slotVal[4][9:2]) && rresp_q == RESP_OKAY;
  endproperty
  a_in2_high: assert property (p_in2_high)
    else $error("input two high byte wrong");

  property p_reset_zero;
    @(posedge core_clk) disable iff (!resetn)
    $rose(resetn) |-> slotVal[0] == RESULT_RST &&
      slotVal[4] == RESULT_RST && slotVal[2] == RESULT_RST &&
      slotVal[3] == RESULT_RST && slotVal[5] == RESULT_RST &&
      slotVal[6] == RESULT_RST;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("result not zero after reset");

  property p_write_inert;
    @(posedge core_clk) disable iff (!resetn)
    awHeld_q && wHeld_q && !intTempLoad |=>
      slotVal[0] == $past(slotVal[0]);
  endproperty
  a_write_inert: assert property (p_write_inert)
    else $error("write changed a stored result");

  property p_inputs_inert;
    @(posedge core_clk) disable iff (!resetn)
    inputLoad == 4'h0 |=>
      slotVal[3] == $past(slotVal[3]) && slotVal[6] == $past(slotVal[6]);
  endproperty
  a_inputs_inert: assert property (p_inputs_inert)
    else $error("input result changed without a load");

  // Registered read and write-address readies must track the hold and valid state
  property p_ready_track;
    @(posedge core_clk) disable iff (!resetn)
    s_axi_arready == !s_axi_rvalid &&
      s_axi_awready == (!awHeld_q && !bvalid_q);
  endproperty
  a_ready_track: assert property (p_ready_track)
    else $error("ready out of step with channel state");

  c_read: cover property (@(posedge core_clk) disable iff (!resetn)
    rvalid_q && s_axi_rready && rresp_q == RESP_OKAY);
  c_write: cover property (@(posedge core_clk) disable iff (!resetn)
    bvalid_q && s_axi_bready);
  c_select: cover property (@(posedge core_clk) disable iff (!resetn)
    wrSel ##1 remoteSel);
  c_slverr: cover property (@(posedge core_clk) disable iff (!resetn)
    rvalid_q && rresp_q == RESP_SLVERR);

endmodule : crr_result_bank

// file: hw/crr_result_slot.sv
// One conversion result holder with its own load strobe.
// Assumes result and strobe come from converter logic on core_clk.
`timescale 1ns/1ns
module crr_result_slot
  import crr_pkg::*;
#(
  parameter logic [RES_W-1:0] RST_VAL = RESULT_RST
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // Converter side
  input  wire logic             loadEn,
  input  wire logic [RES_W-1:0] loadVal,
  // Stored result
  output logic      [RES_W-1:0] value
);

  logic [RES_W-1:0] value_q;

  // Holds the last completed conversion
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      value_q <= RST_VAL;
    end else if (loadEn) begin
      value_q <= loadVal;
    end
  end

  assign value = value_q;

endmodule : crr_result_slot

// file: verif/tb_crr_result_bank.sv
// Self-checking bench for the conversion result register bank.
// Assumes the bank answers AXI4-Lite reads and writes on core_clk.
`timescale 1ns/1ns
module tb_crr_result_bank
  import crr_pkg::*;
();
  // Design ports
  logic             core_clk, resetn;
  logic             intTempLoad, supplyLoad, remoteTempLoad;
  logic [3:0]       inputLoad;
  logic [RES_W-1:0] intTempVal, supplyVal, remoteTempVal;
  logic [RES_W-1:0] inputVal [4];
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic             s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic             s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic             s_axi_rready;
  logic [7:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  // Reference model and scoreboard
  logic [RES_W-1:0] mIt, mSv, mRt;
  logic [RES_W-1:0] mIn [4];
  logic [1:0]       mSel;
  logic [33:0]      rdQ [$];
  logic [1:0]       bQ [$];
  logic [31:0]      st = 32'h0001_0178;
  logic [7:0]       regIx [6] = '{IDX_TEMP_SUPPLY_LOW, IDX_REMOTE_LOW,
    IDX_SUPPLY_HIGH, IDX_INT_TEMP_HIGH, IDX_REMOTE_ONE_HIGH,
    IDX_INPUT_TWO_HIGH};
  int               err_total, n_tests;

  crr_result_bank dut_u (
    .core_clk(core_clk), .resetn(resetn), .intTempLoad(intTempLoad),
    .intTempVal(intTempVal), .supplyLoad(supplyLoad),
    .supplyVal(supplyVal), .remoteTempLoad(remoteTempLoad),
    .remoteTempVal(remoteTempVal), .inputLoad(inputLoad),
    .inputVal(inputVal), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Xorshift source for result values and strobes
  function automatic logic [RES_W-1:0] rnd10();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st[RES_W-1:0];
  endfunction : rnd10

  // Expected register content from the model
  function automatic logic [7:0] expReg(input logic [7:0] idx);
    logic [RES_W-1:0] ch;
    ch = (mSel != 2'h0) ? mRt : mIn[0];
    case (idx)
      IDX_TEMP_SUPPLY_LOW: return {4'h0, mSv[1:0], mIt[1:0]};
      IDX_REMOTE_LOW:      return {mIn[3][1:0], mIn[2][1:0],
                                   mIn[1][1:0], ch[1:0]};
      IDX_SUPPLY_HIGH:     return mSv[9:2];
      IDX_INT_TEMP_HIGH:   return mIt[9:2];
      IDX_REMOTE_ONE_HIGH: return ch[9:2];
      IDX_INPUT_TWO_HIGH:  return mIn[1][9:2];
      default:             return 8'h00;
    endcase
  endfunction : expReg

  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [33:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic hang(input string nm);
    err_total++;
    $display("mismatch %s expected handshake seen none", nm);
    complete_run();
  endtask : hang

  // AXI4-Lite write: address and data offered together
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r);
    logic awDone, wDone;
    int   n;
    awDone = 1'b0;
    wDone = 1'b0;
    n = 0;
    bQ.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1 && !awDone) s_axi_awvalid <= 1'b0;
      if (s_axi_awready === 1'b1) awDone = 1'b1;
      if (s_axi_wready === 1'b1 && !wDone) s_axi_wvalid <= 1'b0;
      if (s_axi_wready === 1'b1) wDone = 1'b1;
      if (++n > 50) hang("write accept");
    end while (!(awDone && wDone));
    do begin
      @(posedge core_clk);
      if (++n > 100) hang("write response");
    end while (s_axi_bvalid !== 1'b1);
  endtask : axiWrite

  // AXI4-Lite read with expected response and data
  task automatic axiRead(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    rdQ.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (++n > 50) hang("read accept");
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge core_clk);
      if (++n > 100) hang("read data");
    end while (s_axi_rvalid !== 1'b1);
  endtask : axiRead

  // Monitor: compare each response with the oldest note
  always @(posedge core_clk) begin
    if (resetn && s_axi_rvalid && s_axi_rready) begin
      if (rdQ.size() == 0) chk("read count", 34'h0, 34'h3_FFFF_FFFF);
      else chk("read", rdQ.pop_front(), {s_axi_rresp, s_axi_rdata});
    end
    if (resetn && s_axi_bvalid && s_axi_bready) begin
      if (bQ.size() == 0) chk("write count", 34'h0, 34'h1);
      else chk("bresp", {32'h0, bQ.pop_front()}, {32'h0, s_axi_bresp});
    end
  end

  task automatic doReset();
    resetn <= 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    mIt = RESULT_RST;
    mSv = RESULT_RST;
    mRt = RESULT_RST;
    foreach (mIn[i]) mIn[i] = RESULT_RST;
    mSel = SELECT_RST;
  endtask : doReset

  // Random strobe mask; unstrobed values must not land
  task automatic loadAll();
    logic [RES_W-1:0] m, v;
    m = rnd10();
    v = rnd10();
    if (m[0]) mIt = v;
    intTempVal <= v;
    intTempLoad <= m[0];
    v = rnd10();
    if (m[1]) mSv = v;
    supplyVal <= v;
    supplyLoad <= m[1];
    v = rnd10();
    if (m[2]) mRt = v;
    remoteTempVal <= v;
    remoteTempLoad <= m[2];
    for (int i = 0; i < 4; i++) begin
      v = rnd10();
      if (m[3+i]) mIn[i] = v;
      inputVal[i] <= v;
    end
    inputLoad <= m[6:3];
    @(posedge core_clk);
    {intTempLoad, supplyLoad, remoteTempLoad, inputLoad} <= 7'h00;
    intTempVal <= rnd10();
    supplyVal <= rnd10();
    @(posedge core_clk);
  endtask : loadAll

  task automatic readAll();
    foreach (regIx[i]) axiRead({regIx[i][5:0], 2'b00},
      {RESP_OKAY, 24'h0, expReg(regIx[i])});
  endtask : readAll

  // Main sequence
  initial begin
    resetn = 1'b0;
    {intTempLoad, supplyLoad, remoteTempLoad, inputLoad} = 7'h00;
    {intTempVal, supplyVal, remoteTempVal} = '0;
    foreach (inputVal[i]) inputVal[i] = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = '0;
    s_axi_wdata = 32'h0;
    doReset();
    readAll();
    axiRead(8'h40, {RESP_SLVERR, 32'h0});
    for (int s = 0; s < 8; s++) begin
      axiWrite({IDX_INPUT_SELECT[5:0], 2'b00}, {29'h0, s[1:0], 1'b0},
               RESP_OKAY);
      mSel = s[1:0];
      axiRead({IDX_INPUT_SELECT[5:0], 2'b00}, {RESP_OKAY, 29'h0, s[1:0], 1'b0});
      loadAll();
      readAll();
    end
    foreach (regIx[i]) begin
      axiWrite({regIx[i][5:0], 2'b00}, {24'h0, st[7:0]}, RESP_OKAY);
      readAll();
    end
    axiWrite(8'h44, 32'h0000_00A5, RESP_SLVERR);
    doReset();
    readAll();
    complete_run();
  end
endmodule : tb_crr_result_bank
